// File: logic/filt_ctrl_top.sv
// record-path input filter control: registers, channel slices and output buffer
`timescale 1ns/10ps
module filt_ctrl_top #(
   parameter int unsigned DW = filt_pkg::SAMPLE_W
) (
   // clock, reset, enable
   input  wire logic                                       clk_in,
   input  wire logic                                       nrst_in,
   input  wire logic                                       ce_in,
   // register port
   input  wire logic [7:0]                                 reg_addr_in,
   input  wire logic [7:0]                                 reg_wdata_in,
   input  wire logic                                       reg_wr_in,
   output logic      [7:0]                                 reg_rdata_out,
   // per-channel target gain, q1.7
   input  wire logic [filt_pkg::NUM_CH*filt_pkg::GAIN_W-1:0] gain_in,
   // samples from the adc side
   input  wire logic                                       smp_valid_in,
   input  wire logic [filt_pkg::NUM_CH*DW-1:0]             smp_data_in,
   output logic                                            smp_ready_out,
   // samples toward the mixer
   output logic                                            mix_valid_out,
   output logic      [filt_pkg::NUM_CH*DW-1:0]             mix_data_out,
   input  wire logic                                       mix_ready_in
);
   localparam int unsigned NCH = filt_pkg::NUM_CH;
   localparam int unsigned FW  = NCH * DW;

   // ==========================================================
   // parameter check
   generate
      if (DW < 8 || DW > 32) begin : g_bad_width
         $error("sample width must be 8 to 32 bits");
      end
   endgenerate

   // ==========================================================
   // state
   typedef struct packed {
      logic [NCH-1:0][7:0]                ctrl;
      logic [filt_pkg::NUM_PATH-1:0][7:0] hpf;
      logic [7:0]                         rdata;
      logic [1:0][FW-1:0]                 slot;      // slot 0 is the head
      logic [1:0]                         slot_vld;
      logic                               in_rdy;
   } state_t;

   localparam state_t RESET_STATE = '{
      ctrl:   {NCH{filt_pkg::CH_RESET}},
      hpf:    {filt_pkg::NUM_PATH{filt_pkg::HP_RESET}},
      in_rdy: 1'b1,
      default: '0};

   state_t            s_q;
   state_t            s_d;
   logic   [FW-1:0]   proc_frame;
   logic              push;
   logic              pop;

   filt_ch_if #(.DW(DW)) ch_if [NCH] ();

   // a sample is taken only while the buffer tail is free
   assign push = ce_in & smp_valid_in & s_q.in_rdy;
   assign pop  = ce_in & s_q.slot_vld[0] & mix_ready_in;

   // ==========================================================
   // channel slices; path index is channel index over two
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_ch
         assign ch_if[g].chan_ctrl   = s_q.ctrl[g];
         assign ch_if[g].hpf_ctrl    = s_q.hpf[g/2];
         assign ch_if[g].gain_target = gain_in[g*filt_pkg::GAIN_W +: filt_pkg::GAIN_W];
         assign ch_if[g].sample_in   = smp_data_in[g*DW +: DW];
         assign ch_if[g].step        = push;
         assign proc_frame[g*DW +: DW] = ch_if[g].sample_out;
         filt_chan #(.DW(DW)) u_chan (
            .clk_in  (clk_in),
            .nrst_in (nrst_in),
            .ce_in   (ce_in),
            .lnk     (ch_if[g])
         );
      end
   endgenerate

   // ==========================================================
   // next state: register writes, readback, two-entry buffer
   always_comb begin
      s_d = s_q;
      if (ce_in) begin
         // writes, reserved bits forced to zero
         if (reg_wr_in) begin
            case (reg_addr_in)
               filt_pkg::PATH1_LEFT_CTRL_ADDR:  s_d.ctrl[0] = reg_wdata_in & filt_pkg::CH_WR_MASK;
               filt_pkg::PATH1_RIGHT_CTRL_ADDR: s_d.ctrl[1] = reg_wdata_in & filt_pkg::CH_WR_MASK;
               filt_pkg::PATH2_LEFT_CTRL_ADDR:  s_d.ctrl[2] = reg_wdata_in & filt_pkg::CH_WR_MASK;
               filt_pkg::PATH2_RIGHT_CTRL_ADDR: s_d.ctrl[3] = reg_wdata_in & filt_pkg::CH_WR_MASK;
               filt_pkg::PATH1_HIGHPASS_ADDR:   s_d.hpf[0]  = reg_wdata_in & filt_pkg::HP_WR_MASK;
               filt_pkg::PATH2_HIGHPASS_ADDR:   s_d.hpf[1]  = reg_wdata_in & filt_pkg::HP_WR_MASK;
               default: ;
            endcase
         end
         // readback of the addressed register, zero when unmapped
         case (reg_addr_in)
            filt_pkg::PATH1_LEFT_CTRL_ADDR:  s_d.rdata = s_q.ctrl[0];
            filt_pkg::PATH1_RIGHT_CTRL_ADDR: s_d.rdata = s_q.ctrl[1];
            filt_pkg::PATH2_LEFT_CTRL_ADDR:  s_d.rdata = s_q.ctrl[2];
            filt_pkg::PATH2_RIGHT_CTRL_ADDR: s_d.rdata = s_q.ctrl[3];
            filt_pkg::PATH1_HIGHPASS_ADDR:   s_d.rdata = s_q.hpf[0];
            filt_pkg::PATH2_HIGHPASS_ADDR:   s_d.rdata = s_q.hpf[1];
            default:                         s_d.rdata = 8'h00;
         endcase
         // drain the head, move the tail forward
         if (pop) begin
            s_d.slot[0]     = s_q.slot[1];
            s_d.slot_vld[0] = s_q.slot_vld[1];
            s_d.slot_vld[1] = 1'b0;
         end
         // fill the first free slot
         if (push) begin
            if (!s_d.slot_vld[0]) begin
               s_d.slot[0]     = proc_frame;
               s_d.slot_vld[0] = 1'b1;
            end else begin
               s_d.slot[1]     = proc_frame;
               s_d.slot_vld[1] = 1'b1;
            end
         end
         s_d.in_rdy = ~s_d.slot_vld[1];
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) s_q <= RESET_STATE;
      else s_q <= s_d;
   end

   // outputs straight from the state
   assign reg_rdata_out = s_q.rdata;
   assign smp_ready_out = s_q.in_rdy;
   assign mix_valid_out = s_q.slot_vld[0];
   assign mix_data_out  = s_q.slot[0];
endmodule : filt_ctrl_top

// File: logic/filt_pkg.sv
// constants shared by the record-path input filter control block
package filt_pkg;

   // ==========================================================
   // sizes
   localparam int unsigned SAMPLE_W  = 24;
   localparam int unsigned NUM_CH    = 4;     // path1 left, path1 right, path2 left, path2 right
   localparam int unsigned NUM_PATH  = 2;
   localparam int unsigned GAIN_W    = 8;
   localparam int unsigned GAIN_FRAC = 7;     // gain is q1.7, 8'h80 is unity
   localparam int unsigned COEF_W    = 16;
   localparam int unsigned COEF_FRAC = 16;

   // ==========================================================
   // register offsets
   localparam logic [7:0] PATH1_LEFT_CTRL_ADDR  = 8'h18;
   localparam logic [7:0] PATH1_RIGHT_CTRL_ADDR = 8'h19;
   localparam logic [7:0] PATH2_LEFT_CTRL_ADDR  = 8'h1a;
   localparam logic [7:0] PATH2_RIGHT_CTRL_ADDR = 8'h1b;
   localparam logic [7:0] PATH1_HIGHPASS_ADDR   = 8'hbc;
   localparam logic [7:0] PATH2_HIGHPASS_ADDR   = 8'hbd;

   // ==========================================================
   // field positions
   localparam int unsigned CH_ON_BIT        = 7;
   localparam int unsigned CH_SILENCE_BIT   = 6;
   localparam int unsigned CH_GLIDE_BIT     = 5;
   localparam int unsigned HP_ON_BIT        = 7;
   localparam int unsigned AUD_CORNER_LSB   = 4;
   localparam int unsigned VOICE_ON_BIT     = 3;
   localparam int unsigned VOICE_CORNER_LSB = 0;

   // ==========================================================
   // write masks and reset values
   localparam logic [7:0] CH_WR_MASK = 8'he0;  // bits 4:0 reserved
   localparam logic [7:0] HP_WR_MASK = 8'hbf;  // bit 6 reserved
   localparam logic [7:0] CH_RESET   = 8'h00;
   localparam logic [7:0] HP_RESET   = 8'h80;

   // ==========================================================
   // one-pole coefficients, 2*pi*fc/fs scaled by 2**16; per-sample, so the corner
   // follows whatever sample rate the stream runs at
   localparam logic [3:0][COEF_W-1:0] AUD_COEF = {
      16'h0089, 16'h0045, 16'h0022, 16'h0011};            // 16, 8, 4, 2 Hz at 48 kHz
   localparam logic [7:0][COEF_W-1:0] VOICE_COEF = {
      16'h506c, 16'h3c51, 16'h2836, 16'h1e29,             // 400, 300, 200, 150 Hz
      16'h141b, 16'h0a0e, 16'h0507, 16'h0081};            // 100, 50, 25, 2.5 Hz at 8 kHz

endpackage : filt_pkg

// File: logic/filt_ch_if.sv
// per-channel control and sample link between the top and a channel slice
`timescale 1ns/10ps
interface filt_ch_if #(parameter int unsigned DW = filt_pkg::SAMPLE_W);
   logic        [7:0]                 chan_ctrl;
   logic        [7:0]                 hpf_ctrl;
   logic        [filt_pkg::GAIN_W-1:0] gain_target;
   logic signed [DW-1:0]              sample_in;
   logic                              step;
   logic signed [DW-1:0]              sample_out;

   modport top  (output chan_ctrl, hpf_ctrl, gain_target, sample_in, step, input sample_out);
   modport chan (input chan_ctrl, hpf_ctrl, gain_target, sample_in, step, output sample_out);
endinterface : filt_ch_if

// File: logic/filt_chan.sv
// one channel slice: audio high-pass, voice high-pass, gain with glide, mute
`timescale 1ns/10ps
module filt_chan #(
   parameter int unsigned DW = filt_pkg::SAMPLE_W
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic ce_in,
   // link to the top
   filt_ch_if.chan   lnk
);
   localparam int unsigned LW = DW + filt_pkg::COEF_FRAC;   // accumulator width
   localparam int unsigned EW = LW + 1;                     // error width

   typedef struct packed {
      logic signed [LW-1:0]              lp_aud;
      logic signed [LW-1:0]              lp_voice;
      logic        [filt_pkg::GAIN_W-1:0] gain;
   } state_t;

   state_t s_q;
   state_t s_d;

   // clamp a wide value into the sample range
   function automatic logic signed [DW-1:0] sat(input logic signed [EW+8:0] v);
      logic signed [EW+8:0] hi;
      logic signed [EW+8:0] lo;
      hi = (EW+9)'(signed'({1'b0, {(DW-1){1'b1}}}));
      lo = -hi - (EW+9)'(1);
      if (v > hi) sat = hi[DW-1:0];
      else if (v < lo) sat = lo[DW-1:0];
      else sat = v[DW-1:0];
   endfunction : sat

   logic                              path_on;
   logic                              silence;
   logic                              glide;
   logic                              hp_on;
   logic                              voice_on;
   logic        [filt_pkg::COEF_W-1:0] aud_c;
   logic        [filt_pkg::COEF_W-1:0] voice_c;
   logic signed [EW-1:0]              err_a;
   logic signed [EW-1:0]              err_v;
   logic signed [EW+16:0]             prod_a;
   logic signed [EW+16:0]             prod_v;
   logic signed [DW-1:0]              y_aud;
   logic signed [DW-1:0]              y_voice;
   logic signed [DW+8:0]              y_gain;

   // decode the control bytes
   assign path_on  = lnk.chan_ctrl[filt_pkg::CH_ON_BIT];
   assign silence  = lnk.chan_ctrl[filt_pkg::CH_SILENCE_BIT];
   assign glide    = lnk.chan_ctrl[filt_pkg::CH_GLIDE_BIT];
   assign hp_on    = lnk.hpf_ctrl[filt_pkg::HP_ON_BIT];
   assign voice_on = lnk.hpf_ctrl[filt_pkg::VOICE_ON_BIT];
   assign aud_c    = filt_pkg::AUD_COEF[lnk.hpf_ctrl[filt_pkg::AUD_CORNER_LSB+:2]];
   assign voice_c  = filt_pkg::VOICE_COEF[lnk.hpf_ctrl[filt_pkg::VOICE_CORNER_LSB+:3]];

   // datapath: x minus running low-pass, then gain, then gate
   always_comb begin
      err_a   = EW'(signed'({lnk.sample_in, {filt_pkg::COEF_FRAC{1'b0}}})) - EW'(s_q.lp_aud);
      prod_a  = err_a * $signed({1'b0, aud_c});
      y_aud   = hp_on ? sat((EW+9)'(err_a >>> filt_pkg::COEF_FRAC)) : lnk.sample_in;
      err_v   = EW'(signed'({y_aud, {filt_pkg::COEF_FRAC{1'b0}}})) - EW'(s_q.lp_voice);
      prod_v  = err_v * $signed({1'b0, voice_c});
      y_voice = voice_on ? sat((EW+9)'(err_v >>> filt_pkg::COEF_FRAC)) : y_aud;
      y_gain  = ((DW+9)'(y_voice) * (DW+9)'($signed({1'b0, s_q.gain})))
                >>> filt_pkg::GAIN_FRAC;   // widened first so the product cannot wrap
      lnk.sample_out = (path_on && !silence) ? sat((EW+9)'(y_gain)) : '0;
   end

   // next state: filter memories advance per accepted sample
   always_comb begin
      s_d = s_q;
      if (ce_in) begin
         if (!path_on || !hp_on) s_d.lp_aud = '0;
         else if (lnk.step) s_d.lp_aud = s_q.lp_aud + LW'(prod_a >>> filt_pkg::COEF_FRAC);
         if (!path_on || !voice_on) s_d.lp_voice = '0;
         else if (lnk.step) s_d.lp_voice = s_q.lp_voice + LW'(prod_v >>> filt_pkg::COEF_FRAC);
         if (!glide) s_d.gain = lnk.gain_target;
         else if (lnk.step && s_q.gain < lnk.gain_target) s_d.gain = s_q.gain + 8'h01;
         else if (lnk.step && s_q.gain > lnk.gain_target) s_d.gain = s_q.gain - 8'h01;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) s_q <= '{gain: 8'h80, default: '0};
      else s_q <= s_d;
   end
endmodule : filt_chan

// File: bench/filt_ctrl_properties.sv
// assertions on the filter control top ports
`timescale 1ns/10ps
module filt_ctrl_properties #(parameter int unsigned DW = 24) (
   // clock and register port
   input wire logic                 clk_in,
   input wire logic                 nrst_in,
   input wire logic                 ce_in,
   input wire logic [7:0]           reg_addr_in,
   input wire logic [7:0]           reg_wdata_in,
   input wire logic                 reg_wr_in,
   input wire logic [7:0]           reg_rdata_out,
   // sample stream
   input wire logic                 smp_valid_in,
   input wire logic                 smp_ready_out,
   input wire logic                 mix_valid_out,
   input wire logic [4*DW-1:0]      mix_data_out,
   input wire logic                 mix_ready_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic on_q;
   // set once any channel has been switched on since reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         on_q <= 1'b0;
      else if (ce_in && reg_wr_in && reg_wdata_in[7] && reg_addr_in inside {[8'h18:8'h1b]})
         on_q <= 1'b1;
   end
   ch_reserved_a: assert property (
      ce_in && reg_addr_in inside {[8'h18:8'h1b]} |=> reg_rdata_out[4:0] == 5'h00)
      else $error("channel reserved bits read nonzero");
   hp_reserved_a: assert property (
      ce_in && reg_addr_in inside {8'hbc, 8'hbd} |=> !reg_rdata_out[6])
      else $error("high-pass reserved bit reads nonzero");
   ch_write_a: assert property (
      (ce_in && reg_wr_in && reg_addr_in inside {[8'h18:8'h1b]})
      ##1 (ce_in && !reg_wr_in && $stable(reg_addr_in))
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'he0))
      else $error("channel control readback wrong");
   hp_write_a: assert property (
      (ce_in && reg_wr_in && reg_addr_in inside {8'hbc, 8'hbd})
      ##1 (ce_in && !reg_wr_in && $stable(reg_addr_in))
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'hbf))
      else $error("high-pass control readback wrong");
   zero_off_a: assert property (
      mix_valid_out && !on_q |-> mix_data_out == '0)
      else $error("disabled channels gave nonzero samples");
   take_out_a: assert property (
      smp_valid_in && smp_ready_out && ce_in |=> mix_valid_out)
      else $error("taken frame not offered to mixer");
   hold_out_a: assert property (
      mix_valid_out && !(mix_ready_in && ce_in) |=> mix_valid_out && $stable(mix_data_out))
      else $error("output frame changed before taken");
   full_stall_a: assert property (
      !smp_ready_out && !(mix_valid_out && mix_ready_in && ce_in) |=> !smp_ready_out)
      else $error("ready rose without a pop");
endmodule : filt_ctrl_properties

// File: bench/mix_sink.sv
// mixer model: takes output frames, stalls on command
`timescale 1ns/10ps
module mix_sink #(parameter int unsigned W = 96) (
   input wire logic         clk_in,
   input wire logic         stall_in,
   input wire logic         valid_in,
   input wire logic [W-1:0] data_in,
   output logic             ready_out
);
   logic [W-1:0] got [$]; // frames taken, oldest first
   initial ready_out = 1'b1;
   // take the head when ready, then follow the stall command
   always @(posedge clk_in) begin
      if (valid_in && ready_out)
         got.push_back(data_in);
      ready_out <= !stall_in;
   end
endmodule : mix_sink

// File: bench/adc_input_filter_control_tb.sv
// testbench for the record-path input filter control
`timescale 1ns/10ps
module adc_input_filter_control_tb;
   localparam logic [7:0] RA [6] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'hbc, 8'hbd};
   localparam logic [23:0] X = 24'h100000;
   logic        clk_in, nrst_in, ce_in, reg_wr_in, smp_valid_in, stall;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [31:0] gain_in;
   logic [95:0] smp_data_in, mix_data_out;
   logic        smp_ready_out, mix_valid_out, mix_ready_in;
   int          error_cnt = 0;
   int          comparisons = 0;
   filt_ctrl_top uut (.clk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rdata_out, .gain_in, .smp_valid_in, .smp_data_in, .smp_ready_out, .mix_valid_out,
      .mix_data_out, .mix_ready_in);
   mix_sink sink (.clk_in, .stall_in(stall), .valid_in(mix_valid_out),
      .data_in(mix_data_out), .ready_out(mix_ready_in));
   task chk(input logic [95:0] s, input logic [95:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in) reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in) reg_wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in) reg_addr_in <= a;
      repeat (2) @(posedge clk_in);
      #1 d = reg_rdata_out;
   endtask : rd
   // offer one frame, held until taken
   task send(input logic [23:0] x);
      int n;
      n = 0;
      @(posedge clk_in) smp_valid_in <= 1'b1;
      smp_data_in <= {4{x}};
      do @(posedge clk_in); while (!smp_ready_out && ++n < 60);
      smp_valid_in <= 1'b0;
      chk(n < 60, 1);
   endtask : send
   task take(output logic [95:0] v);
      int n;
      n = 0;
      while (sink.got.size() == 0 && n++ < 60) @(posedge clk_in);
      v = sink.got.size() ? sink.got.pop_front() : 'x;
   endtask : take
   task t_reset;
      logic [7:0] d;
      logic [95:0] v;
      foreach (RA[i]) begin
         rd(RA[i], d);
         chk(d, i < 4 ? 8'h00 : 8'h80);
      end
      rd(8'h20, d);
      chk(d, 8'h00);
      send(X);
      take(v);
      chk(v, 96'h0);
   endtask : t_reset
   task t_mask;
      logic [7:0] d;
      foreach (RA[i]) begin
         wr(RA[i], 8'hff);
         rd(RA[i], d);
         chk(d, i < 4 ? 8'he0 : 8'hbf);
      end
   endtask : t_mask
   // enable, mute and bypass per channel
   task t_gate;
      logic [95:0] v;
      foreach (RA[i]) wr(RA[i], i == 1 ? 8'hc0 : i == 3 ? 8'h40 : i < 4 ? 8'h80 : 8'h00);
      send(X);
      take(v);
      chk(v, {24'h0, X, 24'h0, X});
   endtask : t_gate
   task t_gain;
      logic [95:0] v;
      @(posedge clk_in) gain_in[23:16] <= 8'h40;
      send(X);
      take(v);
      chk(v[71:48], 24'h080000);
      wr(8'h1a, 8'ha0);
      @(posedge clk_in) gain_in[23:16] <= 8'h80;
      send(X);
      take(v);
      chk(v[71:48], 24'h080000);
      send(X);
      take(v);
      chk(v[71:48], 24'h082000);
   endtask : t_gain
   // every audio and voice corner, two frames each with a varying gap
   task t_corner;
      logic [95:0] v;
      logic [15:0] k;
      wr(8'h1a, 8'h80);
      for (int i = 0; i < 12; i++) begin
         k = i < 4 ? filt_pkg::AUD_COEF[i] : filt_pkg::VOICE_COEF[i-4];
         wr(8'hbd, 8'h00);
         wr(8'hbd, i < 4 ? 8'h80 | 8'(i << 4) : 8'h08 | 8'(i - 4));
         send(X);
         take(v);
         chk(v[71:48], X);
         repeat (i) @(posedge clk_in);
         send(X);
         take(v);
         chk(v[71:48], X - {k, 4'h0});
      end
      // negative sample through the audio high-pass from a cleared memory
      wr(8'hbd, 8'h00);
      wr(8'hbd, 8'h80);
      send(24'hf00000);
      take(v);
      chk(v[71:48], 24'hf00000);
   endtask : t_corner
   // fill the buffer against a stalled mixer, freeze, then drain in order
   task t_buffer;
      logic [95:0] v;
      wr(8'hbd, 8'h00);
      @(posedge clk_in) stall <= 1'b1;
      send(24'h000011);
      send(24'h000022);
      @(posedge clk_in) ce_in <= 1'b0;
      chk(smp_ready_out, 0);
      repeat (2) @(posedge clk_in);
      ce_in <= 1'b1;
      fork
         send(24'h000033);
         begin
            repeat (4) @(posedge clk_in);
            stall <= 1'b0;
         end
      join
      for (int n = 1; n < 4; n++) begin
         take(v);
         chk(v, {24'h0, 24'(n * 17), 24'h0, 24'(n * 17)});
      end
   endtask : t_buffer
   task conclude;
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   // clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // reset, then the scenarios
   initial begin
      {nrst_in, reg_wr_in, smp_valid_in, stall, reg_addr_in, reg_wdata_in, smp_data_in} = '0;
      ce_in = 1'b1;
      gain_in = {4{8'h80}};
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset;
      t_mask;
      t_gate;
      t_gain;
      t_corner;
      t_buffer;
      conclude;
   end
   // watchdog
   initial begin
      #2000000;
      error_cnt++;
      conclude;
   end
endmodule : adc_input_filter_control_tb
bind filt_ctrl_top filt_ctrl_properties #(.DW(DW)) chk_i (.clk_in, .nrst_in, .ce_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .smp_valid_in, .smp_ready_out,
   .mix_valid_out, .mix_data_out, .mix_ready_in);
